// ===== inc/rcf_pkg.sv
// Package for the reset-cause flag block: register map, field positions, types
package rcf_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 4'hc;

  // ----------------------------------------------------------------------
  // Flag register fields
  // ----------------------------------------------------------------------
  localparam int BIT_STK_OVF = 7;
  localparam int BIT_STK_UNF = 6;
  localparam int BIT_UNUSED = 5;
  localparam int BIT_WDT_N = 4;
  localparam int BIT_PIN_N = 3;
  localparam int BIT_INSTR_N = 2;
  localparam int BIT_POR_N = 1;
  localparam int BIT_BROWN_N = 0;

  // Implemented bits, and the value forced by a power-on or brown-out reset
  localparam logic [7:0] FLAG_MASK = 8'hdf;
  localparam logic [7:0] FLAG_PWR_VAL = 8'h1c;
  // Value held under the block's own reset: every flag inactive
  localparam logic [7:0] FLAG_RST_VAL = 8'h1f;

  // Interrupt status layout: one bit per reset cause
  localparam int IRQ_W = 7;
  localparam logic [IRQ_W-1:0] IRQ_ZERO = 7'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // One strobe per reset source
  typedef struct packed {
    logic stackOver;
    logic stackUnder;
    logic watchdog;
    logic pin;
    logic instr;
    logic powerOn;
    logic brownOut;
  } rcf_cause_t;

endpackage : rcf_pkg

// ===== src/rcf_reset_cause_flags.sv
// Reset-cause flag register with AXI4-Lite access and a cause interrupt
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// - A reset other than power-on or brown-out updates only its own cause flag
// - Software clears flags; hardware also clears them on reset events
// - Software may set flags; no reset follows
// - Bit 7 stack overflow, set high by hardware
// - Bit 6 stack underflow, set high by hardware
// - Bit 5 unimplemented, always reads zero
// - Bit 4 watchdog flag, cleared low on timeout
// - Bit 3 pin flag, cleared low on pin reset
// - Bit 2 instruction flag, cleared low on instruction
// - Bit 1 power-on flag cleared; software re-sets
// - Bit 0 brown-out cleared on power/brown-out reset
// - Power reset: stack zero, watchdog, pin and instruction flags one
module rcf_reset_cause_flags
  import rcf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Reset-cause strobes from the reset sources, one cycle each
  input wire rcf_cause_t causeStb,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flag register image and interrupt
  output logic [7:0] resetCauseFlags,
  output logic irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] flags_ff;
  logic [IRQ_W-1:0] irqStat_ff;
  logic [IRQ_W-1:0] irqEn_ff;
  logic irq_ff;
  logic awHeld_ff;
  logic wHeld_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [7:0] wData_ff;
  logic wLane0_ff;
  logic bValid_ff;
  logic [1:0] bResp_ff;
  logic rValid_ff;
  logic [DATA_W-1:0] rData_ff;
  logic [1:0] rResp_ff;
  logic awReady_ff;
  logic wReady_ff;
  logic arReady_ff;

  // Decodes a byte offset into a known-register hit
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == OFS_FLAGS) || (a == OFS_IRQ_STAT) ||
      (a == OFS_IRQ_CLR) || (a == OFS_IRQ_EN);
  endfunction : isMapped

  // ----------------------------------------------------------------------
  // Write channel: address and data accepted in either order
  // ----------------------------------------------------------------------
  // A half moves only on an edge where its registered ready is high
  wire awTake = s_axi_awvalid && awReady_ff;
  wire wTake = s_axi_wvalid && wReady_ff;
  wire haveAw = awHeld_ff || awTake;
  wire haveW = wHeld_ff || wTake;
  wire wrFire = haveAw && haveW && !bValid_ff;
  wire [ADDR_W-1:0] wrAddr = awHeld_ff ? awAddr_ff : s_axi_awaddr;
  wire [7:0] wrByte = wHeld_ff ? wData_ff : s_axi_wdata[7:0];
  wire wrLane0 = wHeld_ff ? wLane0_ff : s_axi_wstrb[0];
  wire wrOk = isMapped(wrAddr);
  wire wrFlags = wrFire && wrLane0 && (wrAddr == OFS_FLAGS);
  wire wrClr = wrFire && wrLane0 && (wrAddr == OFS_IRQ_CLR);
  wire wrEn = wrFire && wrLane0 && (wrAddr == OFS_IRQ_EN);

  // Holding registers for the half of a write that arrived first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= OFS_FLAGS;
      wData_ff <= 8'h00;
      wLane0_ff <= 1'b0;
    end else begin
      awHeld_ff <= haveAw && !wrFire;
      wHeld_ff <= haveW && !wrFire;
      if (awTake) begin
        awAddr_ff <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_ff <= s_axi_wdata[7:0];
        wLane0_ff <= s_axi_wstrb[0];
      end
    end
  end

  // Write response, held until the master takes it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
    end else if (wrFire) begin
      bValid_ff <= 1'b1;
      bResp_ff <= wrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Flag register update
  // ----------------------------------------------------------------------
  // Hardware-owned bits this cycle and the values they take
  wire powerEvt = causeStb.powerOn || causeStb.brownOut;
  logic [7:0] hwMask;
  logic [7:0] hwVal;
  always_comb begin
    hwMask = 8'h00;
    hwVal = 8'h00;
    if (powerEvt) begin
      hwMask = FLAG_MASK;
      hwVal = FLAG_PWR_VAL;
      // Brown-out alone leaves the power-on flag as it was
      hwMask[BIT_POR_N] = causeStb.powerOn;
    end
    if (causeStb.stackOver) begin
      hwMask[BIT_STK_OVF] = 1'b1;
      hwVal[BIT_STK_OVF] = 1'b1;
    end
    if (causeStb.stackUnder) begin
      hwMask[BIT_STK_UNF] = 1'b1;
      hwVal[BIT_STK_UNF] = 1'b1;
    end
    if (causeStb.watchdog) begin
      hwMask[BIT_WDT_N] = 1'b1;
      hwVal[BIT_WDT_N] = 1'b0;
    end
    if (causeStb.pin) begin
      hwMask[BIT_PIN_N] = 1'b1;
      hwVal[BIT_PIN_N] = 1'b0;
    end
    if (causeStb.instr) begin
      hwMask[BIT_INSTR_N] = 1'b1;
      hwVal[BIT_INSTR_N] = 1'b0;
    end
  end

  // Software value first, then hardware bits override it
  wire [7:0] swVal = wrFlags ? (wrByte & FLAG_MASK) : flags_ff;
  wire [7:0] nxt_flags = ((swVal & ~hwMask) | (hwVal & hwMask)) & FLAG_MASK;

  // Block reset gives inactive flags; a power strobe then records the cause
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_ff <= FLAG_RST_VAL;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt: sticky cause bits, write-one-to-clear, enable mask
  // ----------------------------------------------------------------------
  wire [IRQ_W-1:0] causeVec = causeStb;
  wire [IRQ_W-1:0] clrVec = wrClr ? wrByte[IRQ_W-1:0] : IRQ_ZERO;
  // Set beats clear so a cause in the clearing cycle is kept
  wire [IRQ_W-1:0] nxt_irqStat = (irqStat_ff & ~clrVec) | causeVec;
  wire nxt_irq = |(nxt_irqStat & irqEn_ff);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStat_ff <= IRQ_ZERO;
      irqEn_ff <= IRQ_ZERO;
      irq_ff <= 1'b0;
    end else begin
      irqStat_ff <= nxt_irqStat;
      if (wrEn) begin
        irqEn_ff <= wrByte[IRQ_W-1:0];
      end
      irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Read channel: one cycle from address to data
  // ----------------------------------------------------------------------
  wire arTake = s_axi_arvalid && arReady_ff;
  logic [DATA_W-1:0] rdMux;
  always_comb begin
    rdMux = '0;
    unique case (s_axi_araddr)
      OFS_FLAGS: rdMux[7:0] = flags_ff & FLAG_MASK;
      OFS_IRQ_STAT: rdMux[IRQ_W-1:0] = irqStat_ff;
      OFS_IRQ_EN: rdMux[IRQ_W-1:0] = irqEn_ff;
      default: rdMux = '0; // Clear register and holes read zero
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rValid_ff <= 1'b0;
      rData_ff <= '0;
      rResp_ff <= RESP_OKAY;
    end else if (arTake) begin
      rValid_ff <= 1'b1;
      rData_ff <= rdMux;
      rResp_ff <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Ready lines are flops: high while the matching half is still free
  // A response the master has not yet taken keeps the write side shut
  wire bBusy = bValid_ff && !s_axi_bready;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awReady_ff <= 1'b0;
      wReady_ff <= 1'b0;
      arReady_ff <= 1'b0;
    end else begin
      awReady_ff <= !(haveAw && !wrFire) && !wrFire && !bBusy;
      wReady_ff <= !(haveW && !wrFire) && !wrFire && !bBusy;
      arReady_ff <= !arTake && !(rValid_ff && !s_axi_rready);
    end
  end

  // Acceptance is qualified by the registered ready to match the ports
  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = wReady_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
  assign resetCauseFlags = flags_ff;
  assign irq = irq_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence wdtEvt_s;
    causeStb.watchdog;
  endsequence

  unused_reads_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    !resetCauseFlags[BIT_UNUSED]) else $error("unused flag bit is set");

  ovf_sets_a: assert property (@(posedge clk) disable iff (!rst_n)
    causeStb.stackOver |=> resetCauseFlags[BIT_STK_OVF])
    else $error("stack overflow not recorded");

  unf_sets_a: assert property (@(posedge clk) disable iff (!rst_n)
    causeStb.stackUnder |=> resetCauseFlags[BIT_STK_UNF])
    else $error("stack underflow not recorded");

  wdt_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
    wdtEvt_s |=> !resetCauseFlags[BIT_WDT_N])
    else $error("watchdog flag not cleared");

  pin_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
    causeStb.pin |=> !resetCauseFlags[BIT_PIN_N])
    else $error("pin flag not cleared");

  instr_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
    causeStb.instr |=> !resetCauseFlags[BIT_INSTR_N])
    else $error("instruction flag not cleared");

  por_value_a: assert property (@(posedge clk) disable iff (!rst_n)
    causeStb.powerOn |=> (resetCauseFlags == (FLAG_PWR_VAL & 8'hfc)))
    else $error("power-on image wrong");

  quiet_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (causeStb == '0 && !wrFlags) |=> $stable(resetCauseFlags))
    else $error("flags changed with no cause");

  brown_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
    causeStb.brownOut |=> !resetCauseFlags[BIT_BROWN_N])
    else $error("brown-out flag not cleared");

  hw_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrFlags && causeStb.stackOver && !wrByte[BIT_STK_OVF]) |=>
    resetCauseFlags[BIT_STK_OVF]) else $error("software beat hardware");

  sequence pwrEvt_s;
    causeStb.powerOn || causeStb.brownOut;
  endsequence

  brown_keeps_pwr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (causeStb.brownOut && !causeStb.powerOn && !wrFlags) |=>
    $stable(resetCauseFlags[BIT_POR_N])) else $error("power-on flag disturbed");

  pwr_stack_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    pwrEvt_s ##0 (!causeStb.stackOver && !causeStb.stackUnder) |=>
    (resetCauseFlags[BIT_STK_OVF:BIT_STK_UNF] == 2'h0)) else $error("stack flags kept");

  pwr_cause_ones_a: assert property (@(posedge clk) disable iff (!rst_n)
    pwrEvt_s ##0 (!causeStb.watchdog && !causeStb.pin && !causeStb.instr) |=>
    (resetCauseFlags[BIT_WDT_N:BIT_INSTR_N] == 3'h7)) else $error("cause flags not inactive");

  sw_no_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrFlags && causeStb == '0) |=> $stable(irqStat_ff))
    else $error("software write raised a cause");

  wr_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrFire |=> s_axi_bvalid)
    else $error("write response missing");

  wr_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrFire && !wrOk) |=> (s_axi_bresp == RESP_SLVERR))
    else $error("unmapped write not refused");

  rd_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read data missing");

  rd_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready && !isMapped(s_axi_araddr)) |=>
    (s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)) else $error("unmapped read wrong");

  busy_no_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write ready while response pending");

endmodule : rcf_reset_cause_flags

// ===== tb/rcf_cause_src.sv
// Model of the reset sources that feed cause strobes into the flag block
`timescale 1ns/100ps
module rcf_cause_src
  import rcf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request from the bench
  input wire rcf_cause_t fireReq,
  input wire logic fire,
  // Strobes toward the block
  output rcf_cause_t causeStb
);
  // One-cycle strobe per request; idle low so no stale cause repeats
  always_ff @(posedge clk) begin
    causeStb <= (rst_n && fire) ? fireReq : '0;
  end
endmodule : rcf_cause_src

// ===== tb/tb.sv
// Self-checking bench for the reset-cause flag block
`timescale 1ns/100ps
module tb import rcf_pkg::*;;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk, rst_n, fire, irq;
  rcf_cause_t fireReq, causeStb;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] resetCauseFlags;
  int mismatches, checked;
  // Single causes in turn, and the flag image after each
  logic [6:0] causeTab [5] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04};
  logic [7:0] expTab [5] = '{8'h9f, 8'hdf, 8'hcf, 8'hc7, 8'hc3};

  rcf_cause_src src (.clk, .rst_n, .fireReq, .fire, .causeStb);
  rcf_reset_cause_flags dut (.clk, .rst_n, .causeStb, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .resetCauseFlags, .irq);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang;
    mismatches++;
    $display("[ERR] %0t handshake timeout", $time);
    end_sim;
  endtask : hang

  // Write: offer both halves, drop each once taken, then wait for the response
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d);
    bit aDone, wDone;
    int n;
    aDone = 0;
    wDone = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; !(aDone && wDone); n++) begin
      if (n == 50) hang();
      @(posedge clk);
      if (!aDone && s_axi_awready === 1'b1) begin
        aDone = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready === 1'b1) begin
        wDone = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50) hang();
    rsp = s_axi_bresp;
  endtask : axiWr

  task automatic axiRd(input logic [3:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) break;
    end
    if (n == 50) hang();
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 50) hang();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : axiRd

  task automatic rdChk(input logic [3:0] a, input logic [31:0] exp);
    axiRd(a);
    chk(rd, exp);
  endtask : rdChk

  // Strobe lands one edge after the request; wait for flags and irq to settle
  task automatic pulse(input logic [6:0] c);
    fireReq <= rcf_cause_t'(c);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, fire, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    // Response readies stay high, so every answer is taken as it appears
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    fireReq = '0;
    s_axi_wstrb = 4'hf;
    mismatches = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'(resetCauseFlags), 32'h1f);
    rdChk(OFS_FLAGS, 32'h1f);
    $display("test 1 reset image done");
    // Software set and clear; bit 5 stays zero, no cause recorded
    axiWr(OFS_FLAGS, 32'hff);
    chk(32'(rsp), 32'(RESP_OKAY));
    rdChk(OFS_FLAGS, 32'hdf);
    rdChk(OFS_IRQ_STAT, 32'h0);
    axiWr(OFS_FLAGS, 32'h0);
    rdChk(OFS_FLAGS, 32'h0);
    $display("test 2 software access done");
    // Each single cause other than power-on and brown-out touches only its own bit
    axiWr(OFS_FLAGS, 32'h1f);
    for (int i = 0; i < 5; i++) begin
      pulse(causeTab[i]);
      chk(32'(resetCauseFlags), 32'(expTab[i]));
    end
    rdChk(OFS_FLAGS, 32'hc3);
    $display("test 3 single causes done");
    // Power-on forces the whole image; software re-arms the power flags
    pulse(7'h02);
    chk(32'(resetCauseFlags), 32'h1c);
    axiWr(OFS_FLAGS, 32'h03);
    rdChk(OFS_FLAGS, 32'h03);
    // Brown-out with the power-on flag low: that flag must stay low
    axiWr(OFS_FLAGS, 32'hc1);
    pulse(7'h01);
    chk(32'(resetCauseFlags), 32'h1c);
    // Cause and software write meet on one edge; the cause bit wins
    fireReq <= rcf_cause_t'(7'h40);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    axiWr(OFS_FLAGS, 32'h0);
    chk(32'(resetCauseFlags), 32'h80);
    $display("test 4 power causes done");
    // Interrupt: sticky status, enable, clear and mask
    rdChk(OFS_IRQ_STAT, 32'h7f);
    chk(32'(irq), 32'h0);
    axiWr(OFS_IRQ_EN, 32'h01);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    axiWr(OFS_IRQ_CLR, 32'h7f);
    rdChk(OFS_IRQ_STAT, 32'h0);
    rdChk(OFS_IRQ_CLR, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    pulse(7'h08);
    chk(32'(irq), 32'h0);
    axiWr(OFS_IRQ_STAT, 32'h0);
    rdChk(OFS_IRQ_STAT, 32'h08);
    axiWr(OFS_IRQ_EN, 32'h08);
    rdChk(OFS_IRQ_EN, 32'h08);
    chk(32'(irq), 32'h1);
    $display("test 5 interrupt done");
    // Unaligned address hits no register
    axiRd(4'h2);
    chk(32'(rsp), 32'(RESP_SLVERR));
    chk(rd, 32'h0);
    axiWr(4'h6, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    // Byte lane 0 off: the flag register keeps its value
    s_axi_wstrb <= 4'he;
    axiWr(OFS_FLAGS, 32'h0);
    rdChk(OFS_FLAGS, 32'h80);
    $display("test 6 unmapped done");
    end_sim();
  end
endmodule : tb
